//--- tb/port_partner.sv
// Arbiter, board logic and serial prom beside the shared port
`timescale 1ns/100ps
`default_nettype none
module port_partner
#(
    parameter int GRANT_DELAY = 100
)
(
    input  wire logic       i_clk,
    input  wire logic       i_request_n,
    input  wire logic [7:0] i_dut_data,
    input  wire logic [7:0] i_dut_oe,
    input  wire logic       i_dut_parity,
    input  wire logic       i_dut_parity_oe,
    input  wire logic       i_chip_select,
    input  wire logic       i_board_oe_n,
    input  wire logic       i_strobe_oe,
    input  wire logic [5:0] i_board_value,
    input  wire logic       i_prom_bit,
    output logic            o_grant_n,
    output logic      [7:0] o_data,
    output logic            o_parity
);
    int   wait_q  = 0;
    logic float_q = 1'b0;
    logic board_on;
    // Grant after a delay, withdrawn with the request
    always @(posedge i_clk)
    begin
        float_q <= !float_q;
        if (i_request_n)
            wait_q <= 0;
        else if (wait_q < GRANT_DELAY)
            wait_q <= wait_q + 1;
    end
    assign o_grant_n = !(!i_request_n && wait_q >= GRANT_DELAY);
    assign board_on  = !i_board_oe_n && i_strobe_oe;
    // Undriven pins toggle so stale values never pass
    always_comb
    begin
        for (int i = 0; i < 8; i++)
            o_data[i] = i_dut_oe[i] ? i_dut_data[i] : float_q ^ i[0];
        if (board_on)
            o_data[7:3] = i_board_value[5:1];
        if (i_chip_select)
            o_data[0] = i_prom_bit;
        o_parity = i_dut_parity_oe ? i_dut_parity
                 : (board_on ? i_board_value[0] : float_q);
    end
endmodule // port_partner
`default_nettype wire

//--- tb/tb_prom_port_access.sv
// Self-checking bench for the shared port prom and board access block
`timescale 1ns/100ps
`default_nettype none
module tb_prom_port_access;
    logic       i_clk, i_rst, i_wr, i_rd, i_port_busy, i_port_grant_n;
    logic       i_port_parity_pin, o_port_request_n, o_port_parity_pin;
    logic       o_port_parity_oe, o_prom_chip_select, o_prom_chip_select_oe;
    logic       o_board_write_strobe_pin, o_board_output_enable_n;
    logic       o_board_strobe_oe, prom_bit;
    logic [7:0] i_addr, i_wdata, o_rdata, i_port_data_pins, r;
    logic [7:0] o_port_data_pins, o_port_data_oe;
    logic [5:0] board_value;
    logic [9:0] rows [4] = '{10'h2d7, 10'h121, 10'h00c, 10'h3f8};
    int         err_count = 0;
    int         comparisons = 0;
    int         n;

    prom_port_access dut_u (.*);
    port_partner partner_u (.i_clk(i_clk), .i_request_n(o_port_request_n),
        .i_dut_data(o_port_data_pins), .i_dut_oe(o_port_data_oe),
        .i_dut_parity(o_port_parity_pin), .i_dut_parity_oe(o_port_parity_oe),
        .i_chip_select(o_prom_chip_select && o_prom_chip_select_oe),
        .i_board_oe_n(o_board_output_enable_n),
        .i_strobe_oe(o_board_strobe_oe), .i_board_value(board_value),
        .i_prom_bit(prom_bit), .o_grant_n(i_port_grant_n),
        .o_data(i_port_data_pins), .o_parity(i_port_parity_pin));

    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = !i_clk;
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask

    task automatic waitc(input int c);
        repeat (c) @(posedge i_clk);
        #1;
    endtask

    task automatic complete_run;
        $display("comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    initial
    begin
        #100000;
        err_count++;
        complete_run();
    end

    initial
    begin
        {i_rst, i_port_busy, prom_bit} = 3'b111;
        {i_wr, i_rd, i_addr, i_wdata} = '0;
        board_value = 6'h2d;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        // ****************************************************************
        // Reset, arbitration and ready pacing
        // ****************************************************************
        rd(8'h1d, r); check(r, 8'h00);
        rd(8'h1e, r); check(r, 8'h10);
        rd(8'h55, r); check(r, 8'h00);
        wr(8'h1e, 8'h20); waitc(6);
        check(o_port_request_n, 1'b1);
        check(o_port_data_oe, 8'h00);
        i_port_busy <= 1'b0; waitc(4);
        check(o_port_request_n, 1'b0);
        rd(8'h1e, r); check(r[6], 1'b1);
        waitc(75); rd(8'h1e, r); check(r[4], 1'b0);
        check({o_prom_chip_select_oe, o_port_parity_oe}, 8'h00);
        n = 0;
        while (r[4] !== 1'b1 && n < 200)
        begin
            rd(8'h1e, r);
            n++;
        end
        check(r[4], 1'b1);
        wr(8'h1e, 8'h2e); rd(8'h1e, r); check(r[4], 1'b0);
        check({o_prom_chip_select, o_prom_chip_select_oe}, 8'h03);
        check(o_port_data_pins[2:1], 8'h03);
        check(o_port_data_oe[2:0], 8'h06);
        waitc(65); rd(8'h1e, r); check(r[4], 1'b0);
        check(r[0], 1'b1);
        waitc(12); rd(8'h1e, r); check(r[4], 1'b1);
        wr(8'h1e, 8'h20); waitc(3);
        check({o_prom_chip_select, o_port_data_pins[2:1]}, 8'h00);
        // ****************************************************************
        // Board data, strobe and direction rows
        // ****************************************************************
        foreach (rows[k])
        begin
            wr(8'h1d, rows[k][9:2]); waitc(3);
            check(o_board_write_strobe_pin, rows[k][1]);
            check(o_board_output_enable_n, rows[k][0]);
            check(o_board_strobe_oe, 1'b1);
            if (rows[k][3] == 1'b0)
            begin
                check({o_port_data_pins[7:3], o_port_parity_pin},
                      rows[k][9:4]);
                check({o_port_data_oe[7:3], o_port_parity_oe}, 8'h3f);
            end
            else
            begin
                rd(8'h1d, r); check(r[7:2], board_value);
                check(o_port_data_oe[7:3], 8'h00);
            end
        end
        // ****************************************************************
        // Ownership while busy, then release
        // ****************************************************************
        i_port_busy <= 1'b1; waitc(5);
        check({o_port_request_n, o_board_strobe_oe}, 8'h01);
        wr(8'h1e, 8'h00); waitc(4);
        check(o_port_request_n, 1'b1);
        check(o_port_data_oe, 8'h00);
        check(o_port_parity_oe, 8'h00);
        check({o_prom_chip_select_oe, o_board_strobe_oe}, 8'h00);
        // ****************************************************************
        // Reset in mid-run
        // ****************************************************************
        wr(8'h1d, 8'h03);
        i_rst <= 1'b1;
        waitc(2);
        check({o_port_request_n, o_board_output_enable_n}, 8'h03);
        check(o_port_data_oe, 8'h00);
        check(o_rdata, 8'h00);
        i_rst <= 1'b0;
        rd(8'h1d, r);
        check(r, 8'h00);
        complete_run();
    end
endmodule // tb_prom_port_access
`default_nettype wire

//--- verilog/prom_port_access.sv
// Register access to serial prom and board logic over the shared port
// ****************************************************************
// Behaviour
// (R1) Board data 7..3 to port data 7..3, bit 2 to parity, when granted.
// (R2) Read/write 0 drives written board data onto port and parity.
// (R3) Read/write 1 reads board data from port and parity pins.
// (R4) Write strobe is not rw and strobe; output enable_n is not rw.
// (R5) Mode select raises request once port is not busy elsewhere.
// (R6) Grant hands port data 2..0 and chip select to prom bits.
// (R7) Port stays owned until mode select is cleared.
// (R8) Software sets mode select then polls ready before access.
// (R9) Any prom control write clears ready; it returns after 800 ns.
// (R10) After mode select, ready waits for the sampled grant.
// (R11) Port outputs stay undriven until grant after mode select.
// (R12) Chip select only with its bit, mode select and grant.
// (R13) Shift clock pin 2 high when clock bit and mode select set.
// (R14) Control bit 7 reads the grant pin level.
// (R15) Control bit 6 reads the request output level.
// (R16) Data out bit drives port data pin 1 into prom.
// (R17) Data in bit reads port data pin 0 under mode select.
// (R18) Clearing mode select drops request and releases port.
// ****************************************************************
//
// Design decision made here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module prom_port_access
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    input  wire logic       i_port_busy,
    input  wire logic       i_port_grant_n,
    output logic            o_port_request_n,
    input  wire logic [7:0] i_port_data_pins,
    output logic      [7:0] o_port_data_pins,
    output logic      [7:0] o_port_data_oe,
    input  wire logic       i_port_parity_pin,
    output logic            o_port_parity_pin,
    output logic            o_port_parity_oe,
    output logic            o_prom_chip_select,
    output logic            o_prom_chip_select_oe,
    output logic            o_board_write_strobe_pin,
    output logic            o_board_output_enable_n,
    output logic            o_board_strobe_oe
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [9:0] pin_meta_q;
    logic [9:0] pin_sync_q;

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pin_meta_q <= 10'h3ff;
            pin_sync_q <= 10'h3ff;
        end
        else
        begin
            pin_meta_q <= {i_port_grant_n, i_port_parity_pin,
                           i_port_data_pins};
            pin_sync_q <= pin_meta_q;
        end
    end

    logic       grant;
    logic [7:0] data_in;
    logic       parity_in;
    assign grant     = !pin_sync_q[9];
    assign parity_in = pin_sync_q[8];
    assign data_in   = pin_sync_q[7:0];

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0] board_q;
    logic       mode_q;
    logic       cs_q;
    logic       ck_q;
    logic       do_q;
    logic       wr_board;
    logic       wr_prom;
    logic       ready;
    logic       req_q;
    logic       own_q;

    assign wr_board = i_wr &&
        (i_addr == prom_port_pkg::BOARD_PORT_CONTROL_OFS);
    assign wr_prom  = i_wr &&
        (i_addr == prom_port_pkg::SERIAL_PROM_CONTROL_OFS);

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            board_q <= prom_port_pkg::BOARD_PORT_CONTROL_RST;
        else if (wr_board)
            board_q <= i_wdata;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            {mode_q, cs_q, ck_q, do_q} <= prom_port_pkg::PROM_CTRL_RST;
        else if (wr_prom)
        begin
            mode_q <= i_wdata[prom_port_pkg::SPC_MODE_BIT];
            cs_q   <= i_wdata[prom_port_pkg::SPC_CS_BIT];
            ck_q   <= i_wdata[prom_port_pkg::SPC_CK_BIT];
            do_q   <= i_wdata[prom_port_pkg::SPC_DO_BIT];
        end
    end

    // ************************************************************
    // Arbitration
    // ************************************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            req_q <= 1'b0;
        // R18 drop request
        else if (!mode_q)
            req_q <= 1'b0;
        // R5 request when port idle
        else if (!i_port_busy || own_q)
            req_q <= 1'b1;
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            own_q <= 1'b0;
        else if (!mode_q)
            own_q <= 1'b0;
        // R7 keep ownership
        else if (req_q && grant)
            own_q <= 1'b1;
    end

    // R9 pacing timer
    ready_timer u_ready_timer
    (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_restart (wr_prom),
        .i_hold    (mode_q && !own_q),
        .o_ready   (ready)
    );

    // ************************************************************
    // Port drive
    // ************************************************************
    logic       rw;
    logic [7:0] data_d;
    logic [7:0] oe_d;
    assign rw = board_q[prom_port_pkg::BRD_RW_BIT];

    always_comb
    begin
        // R1 board data to upper pins; R2 write value driven
        data_d = {board_q[7:3], ck_q, do_q, 1'b0};
        // R11 undriven until owned
        oe_d   = 8'h00;
        if (own_q)
        begin
            // R6 prom bits take low pins
            // R13 shift clock; R16 data out
            oe_d[2:1] = 2'b11;
            // R3 read direction releases pins
            oe_d[7:3] = rw ? 5'h00 : 5'h1f;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_port_data_pins <= 8'h00;
            o_port_data_oe   <= 8'h00;
            o_port_parity_pin <= 1'b0;
            o_port_parity_oe <= 1'b0;
        end
        else
        begin
            o_port_data_pins <= data_d;
            o_port_data_oe   <= oe_d;
            // R1 bit 2 to parity pin
            o_port_parity_pin <= board_q[prom_port_pkg::BRD_DATA_LSB];
            o_port_parity_oe <= own_q && !rw;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_port_request_n         <= 1'b1;
            o_prom_chip_select       <= 1'b0;
            o_prom_chip_select_oe    <= 1'b0;
            o_board_write_strobe_pin <= 1'b0;
            o_board_output_enable_n  <= 1'b1;
            o_board_strobe_oe        <= 1'b0;
        end
        else
        begin
            o_port_request_n <= !req_q;
            // R12 chip select gated
            o_prom_chip_select    <= cs_q && own_q;
            o_prom_chip_select_oe <= own_q;
            // R4 strobe equations
            o_board_write_strobe_pin <= !rw &&
                board_q[prom_port_pkg::BRD_STB_BIT];
            o_board_output_enable_n  <= !rw;
            o_board_strobe_oe        <= own_q;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    logic [7:0] rdata_d;
    always_comb
    begin
        rdata_d = 8'h00;
        if (i_addr == prom_port_pkg::BOARD_PORT_CONTROL_OFS)
        begin
            rdata_d = board_q;
            // R3 read pin levels
            if (rw && own_q)
                rdata_d[7:2] = {data_in[7:3], parity_in};
        end
        else if (i_addr == prom_port_pkg::SERIAL_PROM_CONTROL_OFS)
            // R14 grant; R15 request; R17 data in
            rdata_d = {grant, !o_port_request_n, mode_q, ready,
                       cs_q, ck_q, do_q, data_in[0] && mode_q};
    end

    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_rdata <= 8'h00;
        else if (i_rd)
            o_rdata <= rdata_d;
        else
            o_rdata <= 8'h00;
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    sequence s_mode_set;
        wr_prom && i_wdata[prom_port_pkg::SPC_MODE_BIT];
    endsequence

    // Cycles since the last prom control write, saturating
    logic [6:0] gap_q;
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            gap_q <= 7'h00;
        else if (wr_prom)
            gap_q <= 7'h01;
        else if (gap_q != 7'h00 && gap_q != 7'h7f)
            gap_q <= gap_q + 7'h01;
    end

    chk_ready_cleared_write: assert property // R9
        (wr_prom |=> !ready)
        else $error("ready not cleared by write");
    chk_ready_after_delay: assert property // R9
        (gap_q == prom_port_pkg::READY_COUNT && !wr_prom &&
         !(mode_q && !own_q) |=> ready)
        else $error("ready not set after delay");
    chk_ready_waits_grant: assert property // R10
        (mode_q && !own_q |=> !ready)
        else $error("ready before grant");
    chk_no_drive_before: assert property // R11
        (!own_q |=> o_port_data_oe == 8'h00 && !o_prom_chip_select_oe)
        else $error("port driven without grant");
    chk_cs_gated: assert property // R12
        (o_prom_chip_select |-> $past(cs_q) && $past(own_q))
        else $error("chip select without grant");
    chk_request_drop: assert property // R18
        (!mode_q |=> ##1 o_port_request_n)
        else $error("request held without mode");
    chk_mode_requests: assert property // R5
        (s_mode_set ##1 !i_port_busy |=> ##1 !o_port_request_n)
        else $error("request not raised");
    chk_own_held: assert property // R7
        (own_q && mode_q && !wr_prom |=> own_q)
        else $error("ownership lost");
    chk_strobe_eq: assert property // R4
        (1'b1 |=> o_board_write_strobe_pin ==
         (!$past(rw) && $past(board_q[prom_port_pkg::BRD_STB_BIT])))
        else $error("write strobe mismatch");
    chk_clock_pin: assert property // R13
        (own_q && ck_q |=> o_port_data_pins[2] && o_port_data_oe[2])
        else $error("shift clock not driven");
endmodule // prom_port_access
`default_nettype wire

//--- verilog/prom_port_pkg.sv
// Constants for the shared memory port serial prom and board access block
`default_nettype none
package prom_port_pkg;
    // Register offsets
    localparam logic [7:0] BOARD_PORT_CONTROL_OFS  = 8'h1d;
    localparam logic [7:0] SERIAL_PROM_CONTROL_OFS = 8'h1e;
    // Board port control fields
    localparam int BRD_DATA_LSB = 2;
    localparam int BRD_RW_BIT   = 1;
    localparam int BRD_STB_BIT  = 0;
    // Serial prom control fields
    localparam int SPC_GRANT_BIT = 7;
    localparam int SPC_REQ_BIT   = 6;
    localparam int SPC_MODE_BIT  = 5;
    localparam int SPC_RDY_BIT   = 4;
    localparam int SPC_CS_BIT    = 3;
    localparam int SPC_CK_BIT    = 2;
    localparam int SPC_DO_BIT    = 1;
    localparam int SPC_DI_BIT    = 0;
    // Reset values
    localparam logic [7:0] BOARD_PORT_CONTROL_RST = 8'h00;
    localparam logic [3:0] PROM_CTRL_RST          = 4'h0;
    // Ready timer
    localparam int CLK_PERIOD_NS   = 10;
    localparam int READY_DELAY_NS  = 800;
    localparam int READY_CYCLES    =
        (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] READY_COUNT = 7'(READY_CYCLES);
endpackage : prom_port_pkg
`default_nettype wire

//--- verilog/ready_timer.sv
// Pacing timer for the serial prom ready flag
`timescale 1ns/100ps
`default_nettype none
module ready_timer
(
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_restart,
    input  wire logic i_hold,
    output logic      o_ready
);
    logic [6:0] count_q;

    // R9 restart and expire
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            count_q <= 7'h00;
        else if (i_restart)
            count_q <= prom_port_pkg::READY_COUNT;
        else if (count_q != 7'h00)
            count_q <= count_q - 7'h01;
    end

    // R10 grant gates ready
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            o_ready <= 1'b0;
        else if (i_restart)
            o_ready <= 1'b0;
        else
            o_ready <= (count_q <= 7'h01) && !i_hold;
    end
endmodule // ready_timer
`default_nettype wire
